// ==== sld_lamp_driver.sv ====
// Purpose: drives five active-low status lamps from link status
// Assumes: one core clock; status inputs synchronous; strap is a raw pin
// Notes: registers over Avalon-MM, every access answered after one wait cycle
`timescale 1ns/1ns
module sld_lamp_driver #(
  parameter int unsigned TICK_CYC = sld_pkg::TICK_CYC
) (
  input  wire logic                 CLK_IN,
  input  wire logic                 NRST_IN,
  input  wire logic [3:0]           AVS_ADDRESS_IN,
  input  wire logic                 AVS_READ_IN,
  input  wire logic                 AVS_WRITE_IN,
  input  wire logic [31:0]          AVS_WRITEDATA_IN,
  output logic      [31:0]          AVS_READDATA_OUT,
  output logic                      AVS_WAITREQUEST_OUT,
  input  wire sld_pkg::sld_status_t STATUS_IN,
  input  wire logic                 STYLE_STRAP_IN,
  output logic      [5:1]           LAMP_OUT
);
  localparam int unsigned DW = $clog2(TICK_CYC + 1);

  // bit of the tick counter that toggles at the chosen blink rate
  function automatic logic blink_ph(input logic [3:0] tc, input logic [1:0] r);
    return tc[2'd3 - r];
  endfunction : blink_ph

  // load value of the shaping counter: stretch period or blink window
  function automatic logic [4:0] shape_ld(input logic se, input logic [1:0] r);
    return se ? 5'(5'h02 << r) : 5'(5'h10 >> r);
  endfunction : shape_ld

  logic [4:0]  ctrl_q;
  logic [15:0] mode_q;
  logic [16:0] beh_q;
  logic        ack_q;
  logic        strap_s1_q, strap_s2_q, strap_q;
  logic [1:0]  strap_cnt_q;
  logic [DW-1:0] div_q;
  logic [3:0]  tcnt_q;
  logic [2:0]  act_hold_q, col_hold_q;
  logic [5:1]  lamp_q;

  // bus decode
  wire req       = AVS_READ_IN | AVS_WRITE_IN;
  wire wr_en     = AVS_WRITE_IN & ack_q;
  wire rd_en     = AVS_READ_IN & ~ack_q;  // load in the wait cycle, data stands at the accept
  wire hit_ctrl  = AVS_ADDRESS_IN == sld_pkg::OFS_CTRL;
  wire hit_mode  = AVS_ADDRESS_IN == sld_pkg::OFS_MODE;
  wire hit_beh   = AVS_ADDRESS_IN == sld_pkg::OFS_BEHAV;
  wire hit_stat  = AVS_ADDRESS_IN == sld_pkg::OFS_STATUS;
  assign AVS_WAITREQUEST_OUT = req & ~ack_q;

  // control fields
  wire       scheme_bit = ctrl_q[sld_pkg::CTRL_SCHEME];
  wire       iso        = ctrl_q[sld_pkg::CTRL_ISO];
  wire       pd         = ctrl_q[sld_pkg::CTRL_PD];
  wire [1:0] sel        = ctrl_q[sld_pkg::CTRL_SEL +: 2];
  sld_pkg::sld_scheme_t scheme;
  assign scheme = !scheme_bit ? sld_pkg::SCH_CFG :
                  strap_q     ? sld_pkg::SCH_PIN :
                                sld_pkg::SCH_TRI;

  // read mux, unmapped offsets read zero
  wire [31:0] rd_mux =
    hit_ctrl ? {27'h0, ctrl_q} :
    hit_mode ? {16'h0, mode_q} :
    hit_beh  ? {15'h0, beh_q} :
    hit_stat ? {24'h0, scheme, strap_q, lamp_q} : 32'h0;

  // register writes and one-cycle answer
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ctrl_q <= sld_pkg::CTRL_RST;
      mode_q <= sld_pkg::MODE_RST;
      beh_q  <= sld_pkg::BEH_RST;
      ack_q  <= 1'b0;
      AVS_READDATA_OUT <= 32'h0;
    end else begin
      ack_q <= req & ~ack_q;
      if (wr_en && hit_ctrl) ctrl_q <= AVS_WRITEDATA_IN[4:0];
      if (wr_en && hit_mode) mode_q <= AVS_WRITEDATA_IN[15:0];
      if (wr_en && hit_beh)  beh_q  <= AVS_WRITEDATA_IN[16:0];
      if (rd_en) AVS_READDATA_OUT <= rd_mux;
    end
  end

  // strap synchroniser, pin taken once when both stages hold it
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      strap_s1_q  <= 1'b0;
      strap_s2_q  <= 1'b0;
      strap_q     <= 1'b0;
      strap_cnt_q <= 2'h0;
    end else begin
      strap_s1_q <= STYLE_STRAP_IN;
      strap_s2_q <= strap_s1_q;
      // count edges so the reset value of the stages is never captured
      if (strap_cnt_q != 2'h3) strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == 2'h2) strap_q <= strap_s2_q;
    end
  end

  // time base: 25 ms tick and a tick counter for the blink phases
  wire tick = div_q == DW'(TICK_CYC - 1);
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      div_q  <= '0;
      tcnt_q <= 4'h0;
    end else begin
      div_q <= tick ? '0 : div_q + 1'b1;
      if (tick) tcnt_q <= tcnt_q + 4'h1;
    end
  end

  // activity and collision hold, reloaded by each event
  wire st_act  = STATUS_IN.rx_act | STATUS_IN.tx_act;
  wire act_tog = act_hold_q != 3'h0;
  wire col_tog = col_hold_q != 3'h0;
  wire tph     = tcnt_q[1];  // 10 Hz toggle phase
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      act_hold_q <= 3'h0;
      col_hold_q <= 3'h0;
    end else begin
      if (st_act) act_hold_q <= sld_pkg::HOLD_TICKS;
      else if (tick && act_tog) act_hold_q <= act_hold_q - 3'h1;
      if (STATUS_IN.col) col_hold_q <= sld_pkg::HOLD_TICKS;
      else if (tick && col_tog) col_hold_q <= col_hold_q - 3'h1;
    end
  end

  // link decode, 1 means lamp lit
  wire lk   = STATUS_IN.link_up;
  wire l10  = lk & (STATUS_IN.speed == sld_pkg::SPD_10);
  wire l100 = lk & (STATUS_IN.speed == sld_pkg::SPD_100);
  wire l1g  = lk & (STATUS_IN.speed == sld_pkg::SPD_1000);
  wire tog_act = act_tog & ~tph;  // lamp dark in this half of a toggle

  // per-pin scheme lamps
  wire sel_ok = sel != sld_pkg::SEL_RSVD;
  wire pp5 = sel_ok & l100 & ~(sel == sld_pkg::SEL_ACT & tog_act);
  wire pp4 = sel_ok & l1g & ~(sel == sld_pkg::SEL_ACT & tog_act);
  wire pp3_lk = (sel == sld_pkg::SEL_DUP) ? lk & STATUS_IN.full_dup : lk;
  wire pp3 = sel_ok & (col_tog ? tph : pp3_lk);
  wire pp2 = lk;
  wire pp1 = act_tog & tph;

  // two-pin colour scheme lamps
  wire tri_on = act_tog ? tph : 1'b1;
  wire tc2 = (l1g | l10) & tri_on;
  wire tc1 = (l100 | l10) & tri_on;

  // configurable scheme, one shaper per lamp 1..4
  logic [3:0] cfg_on;
  wire act_sel = beh_q[sld_pkg::BEH_TXONLY] ? STATUS_IN.tx_act : st_act;
  for (genvar i = 0; i < 4; i++) begin : g_cfg
    wire [3:0] code = mode_q[4*i +: 4];
    wire       sec  = ~beh_q[sld_pkg::BEH_CDIS + i];
    wire       se   = beh_q[sld_pkg::BEH_STR + i];
    wire [1:0] r    = beh_q[sld_pkg::BEH_RATE + 2*i +: 2];
    wire       is_col = (code == 4'h8) | (code == 4'h9);
    wire       evt  = is_col ? STATUS_IN.col : act_sel;
    logic [4:0] cnt_q, gap_q;
    wire        busy = cnt_q != 5'h0;
    wire        ind  = se ? busy : busy & blink_ph(tcnt_q, r);
    logic       prim;
    // primary status of each function code
    always_comb begin
      case (code)
        4'h0:    prim = lk;
        4'h1:    prim = l1g;
        4'h2:    prim = l100;
        4'h3:    prim = l10;
        4'h4:    prim = l100 | l1g;
        4'h5:    prim = l10 | l1g;
        4'h6:    prim = l10 | l100;
        4'h8:    prim = lk & STATUS_IN.full_dup;
        4'hC:    prim = STATUS_IN.pd_fault;
        4'hF:    prim = 1'b1;
        default: prim = 1'b0;  // 14 and reserved codes
      endcase
    end
    // primary with superimposed secondary activity
    assign cfg_on[i] = (code <= 4'h6) ? prim & ~(sec & ind) :
                       (code == 4'h8) ? prim | (sec & lk & ind) :
                       (code == 4'h9 || code == 4'hA) ? ind : prim;
    // stretch: reload per event, then a forced dark gap of half a period
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
        cnt_q <= 5'h0;
        gap_q <= 5'h0;
      end else begin
        if (evt && gap_q == 5'h0) cnt_q <= shape_ld(se, r);
        else if (tick && busy) cnt_q <= cnt_q - 5'h1;
        if (tick && cnt_q == 5'h1 && se) gap_q <= 5'(5'h01 << r);
        else if (tick && gap_q != 5'h0) gap_q <= gap_q - 5'h1;
      end
    end
  end

  // lamp select and forcing
  wire off_all = pd | (scheme != sld_pkg::SCH_CFG & iso);
  wire [5:1] on_pin = {pp5, pp4, pp3, pp2, pp1};
  wire [5:1] on_sel =
    (scheme == sld_pkg::SCH_CFG) ? {1'b0, cfg_on} :
    (scheme == sld_pkg::SCH_TRI) ? {pp5, pp4, pp3, tc2, tc1} : on_pin;
  wire [5:1] lamp_d = off_all ? 5'h1F : ~on_sel;

  // lamp output flops
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) lamp_q <= 5'h1F;
    else          lamp_q <= lamp_d;
  end
  assign LAMP_OUT = lamp_q;

  // checks
  a_pd_all_off: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    pd |=> LAMP_OUT == 5'h1F) else $error("lamp lit during power-down");
  a_iso_all_off: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    iso && scheme_bit |=> LAMP_OUT == 5'h1F) else $error("lamp lit during isolate");
  a_cfg_lamp5: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    !scheme_bit |=> LAMP_OUT[5]) else $error("lamp 5 lit in configurable scheme");
  a_pin_link2: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    scheme == sld_pkg::SCH_PIN && !iso && !pd |=> LAMP_OUT[2] == !$past(lk))
    else $error("lamp 2 does not follow link");
  a_code_force_on: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    !scheme_bit && !pd && mode_q[3:0] == 4'hF |=> !LAMP_OUT[1])
    else $error("code 15 did not light lamp 1");
  a_code_force_off: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    !scheme_bit && mode_q[7:4] == 4'hE |=> LAMP_OUT[2]) else $error("code 14 lit lamp 2");
  a_tri_link_down: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    scheme == sld_pkg::SCH_TRI && !lk |=> LAMP_OUT[2:1] == 2'h3)
    else $error("colour lamps lit with link down");
  a_tri_1g_idle: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    scheme == sld_pkg::SCH_TRI && l1g && !act_tog && !iso && !pd
    |=> LAMP_OUT[2:1] == 2'h1) else $error("1000 idle pattern wrong");
  a_hold_reload: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    st_act |=> act_hold_q == sld_pkg::HOLD_TICKS) else $error("activity hold not loaded");
  a_sel_rsvd: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    scheme == sld_pkg::SCH_PIN && sel == sld_pkg::SEL_RSVD |=> LAMP_OUT[5:3] == 3'h7)
    else $error("reserved selector lit lamps 5..3");
  a_bus_answer: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    req && !ack_q |-> AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT)
    else $error("bus answer not after one wait cycle");

  // per-pin 100 lamp follows its link while not toggling
  a_pin_lamp5: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    scheme == sld_pkg::SCH_PIN && !iso && !pd && sel_ok && !act_tog
    |=> LAMP_OUT[5] == !$past(l100)) else $error("lamp 5 does not follow the 100 link");

  // per-pin 1000 lamp follows its link while not toggling
  a_pin_lamp4: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    scheme == sld_pkg::SCH_PIN && !iso && !pd && sel_ok && !act_tog
    |=> LAMP_OUT[4] == !$past(l1g)) else $error("lamp 4 does not follow the 1000 link");

  // duplex selector keeps lamp 3 dark on half duplex
  a_pin_dup_half: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    scheme == sld_pkg::SCH_PIN && !iso && !pd && sel == sld_pkg::SEL_DUP && !col_tog &&
    !STATUS_IN.full_dup |=> LAMP_OUT[3]) else $error("lamp 3 lit on half duplex");

  // collision toggling darkens lamp 3 in the low phase
  a_pin_col_dark: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    scheme == sld_pkg::SCH_PIN && !iso && !pd && col_tog && !tph
    |=> LAMP_OUT[3]) else $error("lamp 3 not toggling on collision");

  // activity lamp dark with no activity held
  a_pin_act_idle: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    scheme == sld_pkg::SCH_PIN && !act_tog |=> LAMP_OUT[1])
    else $error("lamp 1 lit without activity");

  // colour scheme, 10 link lights both pins
  a_tri_10_idle: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    scheme == sld_pkg::SCH_TRI && l10 && !act_tog && !iso && !pd
    |=> LAMP_OUT[2:1] == 2'h0) else $error("10 idle pattern wrong");

  // colour scheme, 100 link lights lamp 1 only
  a_tri_100_idle: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    scheme == sld_pkg::SCH_TRI && l100 && !act_tog && !iso && !pd
    |=> LAMP_OUT[2:1] == 2'h2) else $error("100 idle pattern wrong");

  // colour scheme leaves the speed lamps in per-pin use
  a_tri_upper_pins: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    scheme == sld_pkg::SCH_TRI && !iso && !pd && sel_ok && !act_tog
    |=> LAMP_OUT[5:4] == {!$past(l100), !$past(l1g)}) else $error("lamps 5 and 4 wrong");

  // hold only moves on a tick or an event
  a_hold_steady: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    !st_act && !tick |=> act_hold_q == $past(act_hold_q))
    else $error("activity hold moved without a tick");

  // combine disabled shows the primary link status only
  a_cfg_no_combine: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    !scheme_bit && !pd && mode_q[15:12] == 4'h1 && beh_q[sld_pkg::BEH_CDIS + 3]
    |=> LAMP_OUT[4] == !$past(l1g)) else $error("lamp 4 shows activity with combine off");

  // fault code follows the parallel-detect fault
  a_cfg_fault_code: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    !scheme_bit && !pd && mode_q[11:8] == 4'hC
    |=> LAMP_OUT[3] == !$past(STATUS_IN.pd_fault)) else $error("code 12 lamp wrong");

  // captured strap never changes until the next reset
  a_strap_kept: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    strap_cnt_q == 2'h3 |=> $stable(strap_q)) else $error("strap changed after capture");
endmodule : sld_lamp_driver

// ==== sld_lamp_driver_tb_top.sv ====
// Purpose: self-checking bench for the status lamp driver
// Assumes: tick shortened to 4 cycles, so toggling is fast in simulation
// Notes: register access over Avalon-MM, random link status, fixed seed
`timescale 1ns/1ns
module sld_lamp_driver_tb_top;
  logic                 clk = 1'b0;
  logic                 nrst_n = 1'b0;
  logic [3:0]           addr = 4'h0;
  logic                 rd = 1'b0;
  logic                 wr = 1'b0;
  logic [31:0]          wdata = 32'h0;
  logic [31:0]          rdata;
  logic                 wrq;
  logic                 strap = 1'b1;
  logic [5:1]           lamp;
  logic [5:1]           lit;
  sld_pkg::sld_status_t st = '0;
  int                   n_errors = 0;
  int                   cmp_count = 0;
  // free-running core clock
  always #5 clk = ~clk;
  sld_lamp_driver #(.TICK_CYC(4)) sld_lamp_driver_inst (.CLK_IN(clk), .NRST_IN(nrst_n),
    .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wrq), .STATUS_IN(st),
    .STYLE_STRAP_IN(strap), .LAMP_OUT(lamp));
  sld_lamp_model sld_lamp_model_inst (.LAMP_IN(lamp), .LIT_OUT(lit));
  // verdict and end of run
  task automatic finish_test;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic chk_lamp(input logic [5:1] e);
    cmp_count++;
    if (lamp !== e) begin
      n_errors++;
      $display("MISMATCH %0t lamps %b expected %b", $time, lamp, e);
    end
  endtask : chk_lamp
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %0t value %h expected %h", $time, g, e);
    end
  endtask : chk_val
  // hold the request until waitrequest is seen low at a rising edge
  task automatic bus_wait;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (wrq !== 1'b0 && i < 20);
    if (wrq !== 1'b0) begin
      n_errors++;
      $display("MISMATCH %0t bus wait timed out", $time);
      finish_test;
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus_wait
  task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    bus_wait;
  endtask : bus_write
  task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    bus_wait;
    d = rdata;
  endtask : bus_read
  // expected per-pin lamps with no events pending
  function automatic logic [5:1] pin_exp(sld_pkg::sld_status_t s, logic [1:0] sel);
    pin_exp[5] = !(s.link_up && s.speed == sld_pkg::SPD_100);
    pin_exp[4] = !(s.link_up && s.speed == sld_pkg::SPD_1000);
    pin_exp[3] = !(s.link_up && (sel != sld_pkg::SEL_DUP || s.full_dup));
    pin_exp[2] = !s.link_up;
    pin_exp[1] = 1'b1;
    if (sel == sld_pkg::SEL_RSVD) pin_exp[5:3] = 3'h7;
  endfunction : pin_exp
  // expected colour-scheme lamps 2 and 1 with no activity
  function automatic logic [2:1] tri_exp(sld_pkg::sld_status_t s);
    tri_exp[2] = !(s.link_up && s.speed != sld_pkg::SPD_100);
    tri_exp[1] = !(s.link_up && s.speed != sld_pkg::SPD_1000);
  endfunction : tri_exp
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic drive_st(input logic [7:0] s);
    @(posedge clk);
    st <= sld_pkg::sld_status_t'(s);
    settle;
  endtask : drive_st
  task automatic do_reset(input logic s);
    @(posedge clk);
    nrst_n <= 1'b0;
    strap <= s;
    repeat (5) @(posedge clk);
    nrst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : do_reset
  // one-cycle event on top of base, then watch lamp k for both levels
  task automatic pulse_seen(input int k, input logic [7:0] b, input logic [7:0] m,
                            output logic tog);
    logic s0;
    logic s1;
    s0 = 1'b0;
    s1 = 1'b0;
    @(posedge clk);
    st <= sld_pkg::sld_status_t'(b | m);
    @(posedge clk);
    st <= sld_pkg::sld_status_t'(b);
    repeat (40) begin
      @(negedge clk);
      if (lit[k] === 1'b1) s0 = 1'b1;
      if (lit[k] === 1'b0) s1 = 1'b1;
    end
    tog = s0 & s1;
    repeat (60) @(posedge clk);
    @(negedge clk);
  endtask : pulse_seen
  initial begin
    #500_000;
    n_errors++;
    $display("MISMATCH %0t run timed out", $time);
    finish_test;
  end
  // main sequence
  initial begin : main
    logic [31:0] d;
    logic [1:0]  sel;
    logic [7:0]  s;
    logic        tog;
    logic [5:1]  e;
    logic [31:0] bv[4] = '{32'h0, 32'h8, 32'h80, 32'h1_0080};
    logic        ev[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    int          ks[4] = '{1, 1, 3, 4};
    logic [7:0]  ms[4] = '{8'h08, 8'h04, 8'h02, 8'h08};
    logic [1:0]  ss[4] = '{2'h3, 2'h3, 2'h3, 2'h2};
    void'($urandom(46));
    do_reset(1'b1);
    chk_lamp(5'h1F);
    bus_read(4'h0, d);
    chk_val(d, 32'h19);
    bus_read(4'h4, d);
    chk_val(d, 32'h0);
    bus_write(4'h2, 32'hFFFF_FFFF);
    bus_read(4'h2, d);
    chk_val(d, 32'h0);
    bus_read(4'hC, d);
    chk_val(d, 32'h7F);
    for (int i = 0; i < 16; i++) begin
      sel = (i == 0) ? sld_pkg::SEL_RSVD : 2'($urandom_range(3));
      s = {1'($urandom), 2'($urandom_range(2)), 1'($urandom), 4'h0};
      bus_write(4'h0, {27'h0, sel, 3'h1});
      drive_st(s);
      chk_lamp(pin_exp(sld_pkg::sld_status_t'(s), sel));
    end
    for (int i = 0; i < 4; i++) begin
      bus_write(4'h0, {27'h0, ss[i], 3'h1});
      drive_st(8'hD0);
      pulse_seen(ks[i], 8'hD0, ms[i], tog);
      chk_val({31'h0, tog}, 32'h1);
      chk_lamp(pin_exp(sld_pkg::sld_status_t'(8'hD0), ss[i]));
    end
    bus_write(4'h0, 32'h1B);
    settle;
    chk_lamp(5'h1F);
    bus_write(4'h0, 32'h1D);
    settle;
    chk_lamp(5'h1F);
    do_reset(1'b0);
    bus_read(4'hC, d);
    chk_val({24'h0, d[7:5], 5'h0}, 32'hC0);
    for (int i = 0; i < 4; i++) begin
      s = (i == 3) ? 8'h50 : {1'b1, 2'(i), 5'h0};
      drive_st(s);
      e = pin_exp(sld_pkg::sld_status_t'(s), 2'h3);
      chk_lamp({e[5:3], tri_exp(sld_pkg::sld_status_t'(s))});
    end
    pulse_seen(2, 8'hC0, 8'h08, tog);
    chk_val({31'h0, tog}, 32'h1);
    bus_write(4'h0, 32'h1B);
    settle;
    chk_lamp(5'h1F);
    bus_write(4'h0, 32'h18);
    bus_write(4'h4, 32'h1CEF);
    bus_read(4'hC, d);
    chk_val({30'h0, d[7:6]}, 32'h0);
    drive_st(8'hC1);
    chk_lamp(5'h12);
    drive_st(8'hC0);
    chk_lamp(5'h16);
    bus_write(4'h0, 32'h1A);
    settle;
    chk_lamp(5'h16);
    // lamp 4 on code 1: blink, combine off, stretch, tx-only activity
    for (int i = 0; i < 4; i++) begin
      bus_write(4'h8, bv[i]);
      pulse_seen(4, 8'hC0, 8'h08, tog);
      chk_val({31'h0, tog}, {31'h0, ev[i]});
    end
    bus_read(4'h8, d);
    chk_val(d, 32'h1_0080);
    bus_write(4'h0, 32'h1C);
    settle;
    chk_lamp(5'h1F);
    finish_test;
  end
endmodule : sld_lamp_driver_tb_top

// ==== sld_lamp_model.sv ====
// Purpose: model of the discrete lamps hanging on the lamp pins
// Assumes: each lamp sits between supply and pin through a resistor
// Notes: a lamp is lit while its pin is driven low
`timescale 1ns/1ns
module sld_lamp_model (
  input  wire logic [5:1] LAMP_IN,
  output logic      [5:1] LIT_OUT
);
  // current flows only while the pin sinks it
  assign LIT_OUT = ~LAMP_IN;
endmodule : sld_lamp_model

// ==== sld_pkg.sv ====
// Purpose: constants and types for the status lamp driver
// Assumes: 100 MHz core clock; status inputs come from logic on the same clock
// Notes: lamps are active low, a lit lamp is a low output
// Behaviour
// - five lamp outputs, three schemes chosen by scheme bit and style strap
// - scheme bit 1 with strap high selects the per-pin scheme
// - scheme bit 1 with strap low selects the two-pin colour scheme
// - scheme bit 0 selects the configurable scheme, strap ignored
// - per-pin functions follow the two-bit selector; 00b reserved for lamps 5..3
// - lamps 5 and 4 show 100 and 1000 link; selector 10b adds activity toggle
// - lamp 3 shows link, 01b needs full duplex, toggles on collision
// - outputs active low; lamp 2 shows any link, lamp 1 toggles on activity
// - colour scheme: 1000 on lamp 2, 100 on lamp 1, 10 on both
// - colour lamps in use steady without activity, toggling with activity
// - colour scheme only on lamps 1 and 2; lamps 3..5 stay per-pin
// - isolate forces all lamps off in per-pin and colour schemes
// - power-down forces all lamps off in every scheme
// - configurable scheme uses per-pin function codes and behaviour settings
// - configurable scheme drives lamps 1..4; lamp 5 disabled
// - function codes 0..6,8,9,10,12; 14 off, 15 on, others reserved
// - combine shows primary with activity superimposed, else primary only
// - blink 50% duty at 2.5..20 Hz; stretch 50..400 ms
// - stretch: full period per event, trail up to 1.5, gap half
package sld_pkg;
  localparam int unsigned CLK_HZ   = 100_000_000;
  localparam int unsigned TICK_MS  = 25;  // base time step, half of fastest blink
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam logic [2:0]  HOLD_TICKS = 3'h5;  // a full 10 Hz toggle period plus the partial tick
  // register byte offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_MODE   = 4'h4;
  localparam logic [3:0] OFS_BEHAV  = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  // control fields
  localparam int unsigned CTRL_SCHEME = 0;
  localparam int unsigned CTRL_ISO    = 1;
  localparam int unsigned CTRL_PD     = 2;
  localparam int unsigned CTRL_SEL    = 3;
  localparam logic [4:0]  CTRL_RST    = 5'h19;
  // behaviour fields
  localparam int unsigned BEH_CDIS  = 0;
  localparam int unsigned BEH_STR   = 4;
  localparam int unsigned BEH_RATE  = 8;
  localparam int unsigned BEH_TXONLY = 16;
  localparam logic [16:0] BEH_RST   = 17'h00000;
  localparam logic [15:0] MODE_RST  = 16'h0000;
  // per-pin selector and speed codes
  localparam logic [1:0] SEL_RSVD = 2'h0;
  localparam logic [1:0] SEL_DUP  = 2'h1;
  localparam logic [1:0] SEL_ACT  = 2'h2;
  localparam logic [1:0] SPD_10   = 2'h0;
  localparam logic [1:0] SPD_100  = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  typedef enum logic [1:0] {
    SCH_CFG = 2'h0,
    SCH_PIN = 2'h1,
    SCH_TRI = 2'h3
  } sld_scheme_t;
  typedef struct packed {
    logic       link_up;
    logic [1:0] speed;
    logic       full_dup;
    logic       rx_act;
    logic       tx_act;
    logic       col;
    logic       pd_fault;
  } sld_status_t;
endpackage : sld_pkg
